// ===== verilog/gdr_pkg.sv
// constants, encodings and types shared by the gate driver register bank
package gdr_pkg;

  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 5;
  localparam int DATA_W = 11;
  localparam int ADDR_W = 4;
  localparam int RW_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 11;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_OVER = 5'h11;
  localparam logic [4:0] CNT_CMD = 5'h05;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_FAULT_PRIMARY = 4'h0;
  localparam logic [3:0] ADDR_FAULT_SECONDARY = 4'h1;
  localparam logic [3:0] ADDR_DRIVER_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_WRITE_LOCK = 4'h3;

  // ----------------------------------------
  // driver control word fields
  // ----------------------------------------
  localparam int CTL_SCOPE = 10;
  localparam int CTL_UV_DIS = 9;
  localparam int CTL_GDE_DIS = 8;
  localparam int CTL_OVERTEMP_WARNING_REPORT = 7;
  localparam int CTL_MODE_MSB = 6;
  localparam int CTL_MODE_LSB = 5;
  localparam int CTL_RECT = 4;
  localparam int CTL_DIR = 3;
  localparam int CTL_HIZ = 2;
  localparam int CTL_LOW_SIDE_ALL_ON = 1;
  localparam int CTL_CLR = 0;
  localparam logic [10:0] CTL_RST = 11'h000;

  // ----------------------------------------
  // write lock field (bits 10:8 of its word)
  // ----------------------------------------
  localparam int LOCK_MSB = 10;
  localparam int LOCK_LSB = 8;
  localparam logic [2:0] LOCK_ENGAGE = 3'h6;
  localparam logic [2:0] LOCK_RELEASE = 3'h3;
  localparam logic [2:0] LOCK_RST = 3'h3;

  // ----------------------------------------
  // status word fields
  // ----------------------------------------
  localparam int ST_SUMMARY = 10;
  localparam int ST_DS_SUM = 9;
  localparam int ST_GDE = 8;
  localparam int ST_SUPPLY_UNDERVOLTAGE_FLAG = 7;
  localparam int ST_OVERTEMP_SHUTDOWN_FLAG = 6;
  localparam int ST2_OTW = 7;
  localparam int ST2_GUV = 6;
  localparam logic [10:0] ST_RST = 11'h000;

  typedef enum logic [1:0] {
    GDR_PWM_SIX = 2'h0,
    GDR_PWM_THREE = 2'h1,
    GDR_PWM_SINGLE = 2'h2,
    GDR_PWM_INDEP = 2'h3
  } gdr_pwm_e;

  // gray along idle -> shift -> commit
  typedef enum logic [1:0] {
    GDR_IDLE = 2'h0,
    GDR_SHIFT = 2'h1,
    GDR_COMMIT = 2'h3
  } gdr_state_e;

endpackage

// ===== verilog/gdr_sticky.sv
// sticky fault flags: set by detectors, cleared together by software
`timescale 1ns/1ns
module gdr_sticky
  import gdr_pkg::*;
#(
  parameter int W = 11
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_set,
  input wire logic i_clr,
  output logic [W-1:0] o_flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } gdr_sticky_s;

  gdr_sticky_s st_ff;
  gdr_sticky_s nxt_st;

  // set is or-ed after the clear so an event in the clear cycle survives
  always_comb begin
    nxt_st = st_ff;
    nxt_st.flags = (st_ff.flags & ~{W{i_clr}}) | i_set; // R21
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_flags = st_ff.flags;

endmodule // gdr_sticky

// ===== verilog/gdr_bridge_ctrl.sv
// bridge steering: shutdown scope, all_transistors_hiz, low_side_all_on, single-input options
`timescale 1ns/1ns
module gdr_bridge_ctrl
  import gdr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [10:0] i_ctrl,
  input wire logic [5:0] i_ds_flags,
  input wire logic [2:0] i_shunt_flags,
  input wire logic i_phase_c_high_input,
  input wire logic i_phase_c_low_input,
  output logic [2:0] o_halfbridge_off,
  output logic o_all_transistors_hiz,
  output logic o_low_side_all_on,
  output logic o_single_input_direction,
  output logic o_single_input_rectify_async,
  output logic [1:0] o_pwm_mode
);

  typedef struct packed {
    logic [2:0] hb_off;
    logic hiz;
    logic low_side_all_on;
    logic dir;
    logic rect;
    logic [1:0] mode;
  } gdr_bridge_s;

  gdr_bridge_s st_ff;
  gdr_bridge_s nxt_st;
  logic single_mode;
  logic [2:0] phase_oc;

  assign single_mode = (i_ctrl[CTL_MODE_MSB:CTL_MODE_LSB] == GDR_PWM_SINGLE);

  // phase a is ds bits 5:4 and shunt bit 2, c is ds 1:0 and shunt bit 0
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      assign phase_oc[g] = |i_ds_flags[2*g+1:2*g] | i_shunt_flags[g];
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.hb_off = i_ctrl[CTL_SCOPE] ? {3{|phase_oc}} : phase_oc; // R9
    nxt_st.hiz = i_ctrl[CTL_HIZ]; // R16
    nxt_st.low_side_all_on = i_ctrl[CTL_LOW_SIDE_ALL_ON] | (single_mode & i_phase_c_low_input); // R17
    nxt_st.dir = i_ctrl[CTL_DIR] | (single_mode & i_phase_c_high_input); // R15
    nxt_st.rect = i_ctrl[CTL_RECT]; // R14
    nxt_st.mode = i_ctrl[CTL_MODE_MSB:CTL_MODE_LSB]; // R13
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_halfbridge_off = st_ff.hb_off;
  assign o_all_transistors_hiz = st_ff.hiz;
  assign o_low_side_all_on = st_ff.low_side_all_on;
  assign o_single_input_direction = st_ff.dir;
  assign o_single_input_rectify_async = st_ff.rect;
  assign o_pwm_mode = st_ff.mode;

endmodule // gdr_bridge_ctrl

// ===== verilog/gdr_regs.sv
// gate driver fault status and driver control words behind a 16-bit serial port
// Notes on behaviour
// (R1) status words are read-only; writes to them change nothing
// (R2) first word bit 10 is the or of reported faults, mirrors error pin
// (R3) first word bits 9..6: ds overcurrent, gate error, undervoltage, overtemp shutdown
// (R4) first word bits 5..0: ds overcurrent per transistor, a high to c low
// (R5) second word bits 10..8: shunt overcurrent on phases a, b, c
// (R6) second word bit 7 overtemp warning, bit 6 gate supply undervoltage
// (R7) second word bits 5..0: gate-source errors per transistor, a high to c low
// (R8) control word is read/write and resets to zero
// (R9) control bit 10 picks one half-bridge or all three on overcurrent
// (R10) control bit 9 set disables the gate supply undervoltage fault
// (R11) control bit 8 set disables gate drive error detection
// (R12) control bit 7 set lets overtemp warning reach pin and summary bit
// (R13) control bits 6:5 choose six, three, single or independent input scheme
// (R14) single-input: bit 4 clear synchronous, set asynchronous rectification
// (R15) single-input direction is bit 3 or phase c high input pin
// (R16) control bit 2 set puts all six transistors high-impedance
// (R17) control bit 1 turns low sides on; or-ed with phase c low pin in single-input mode
// (R18) writing 1 to control bit 0 clears latched faults; bit self-clears
// (R19) frame is 16 bits msb first: rw, 4 address, 11 data
// (R20) while locked only lock field and control bits 2:0 accept writes
// (R21) fault bits stay set until clear-fault write or reset
// (R22) reads return 11 data bits in the low bits, stored value untouched
`timescale 1ns/1ns
module gdr_regs
  import gdr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // serial port, sampled as synchronous inputs
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // detector events
  input wire logic [5:0] i_ds_overcurrent,
  input wire logic [5:0] i_gs_error,
  input wire logic [2:0] i_shunt_overcurrent,
  input wire logic i_supply_undervoltage,
  input wire logic i_overtemp_shutdown,
  input wire logic i_overtemp_warning,
  input wire logic i_gate_supply_undervoltage,
  // pins used in single-input mode
  input wire logic i_phase_c_high_input,
  input wire logic i_phase_c_low_input,
  // driver steering
  output logic o_error_indicator_n,
  output logic [2:0] o_halfbridge_off,
  output logic o_all_transistors_hiz,
  output logic o_low_side_all_on,
  output logic o_single_input_direction,
  output logic o_single_input_rectify_async,
  output logic [1:0] o_pwm_mode
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    gdr_state_e fsm;
    logic sclk_prev;
    logic [15:0] rx;
    logic [4:0] cnt;
    logic [10:0] tx;
    logic sdo_rel;
    logic [10:0] ctrl;
    logic [2:0] lock;
    logic clr;
    logic fault;
  } gdr_regs_s;

  gdr_regs_s st_ff;
  gdr_regs_s nxt_st;

  logic [9:0] word1_flags;
  logic [10:0] word2_flags;
  logic [9:0] word1_set;
  logic [10:0] word2_set;
  logic [5:0] gs_set;
  logic gate_uv_set;
  logic fault_any;
  logic sclk_fall;
  logic sclk_rise;
  logic [3:0] wr_addr;
  logic [10:0] wr_data;

  // ----------------------------------------
  // fault latching
  // ----------------------------------------
  assign gs_set = i_gs_error & {6{~st_ff.ctrl[CTL_GDE_DIS]}}; // R11
  assign gate_uv_set = i_gate_supply_undervoltage & ~st_ff.ctrl[CTL_UV_DIS]; // R10

  assign word1_set = {|i_ds_overcurrent, |gs_set, i_supply_undervoltage,
                      i_overtemp_shutdown, i_ds_overcurrent}; // R3 R4
  assign word2_set = {i_shunt_overcurrent, i_overtemp_warning, gate_uv_set,
                      gs_set}; // R5 R6 R7

  gdr_sticky #(.W(10)) u_word1 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_set(word1_set),
    .i_clr(st_ff.clr),
    .o_flags(word1_flags)
  );

  gdr_sticky #(.W(11)) u_word2 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_set(word2_set),
    .i_clr(st_ff.clr),
    .o_flags(word2_flags)
  );

  // warning counts only when reporting is on; all else is a fault
  assign fault_any = (|word1_flags) | (|word2_flags[10:8]) | word2_flags[ST2_GUV] |
                     (|word2_flags[5:0]) |
                     (word2_flags[ST2_OTW] & st_ff.ctrl[CTL_OVERTEMP_WARNING_REPORT]); // R2 R12

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  function automatic logic [10:0] read_word(input logic [3:0] addr,
                                            input gdr_regs_s s,
                                            input logic [9:0] w1,
                                            input logic [10:0] w2);
    logic [10:0] r;
    r = '0;
    case (addr)
      ADDR_FAULT_PRIMARY: r = {s.fault, w1}; // R2 R22
      ADDR_FAULT_SECONDARY: r = w2; // R22
      ADDR_DRIVER_CONTROL: r = s.ctrl; // R8
      ADDR_WRITE_LOCK: r = {s.lock, 8'h00};
      default: r = '0;
    endcase
    return r;
  endfunction

  assign sclk_fall = st_ff.sclk_prev & ~i_sclk;
  assign sclk_rise = ~st_ff.sclk_prev & i_sclk;
  assign wr_addr = st_ff.rx[ADDR_MSB:ADDR_LSB];
  assign wr_data = st_ff.rx[DATA_W-1:0];

  // ----------------------------------------
  // frame engine and write commit
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclk_prev = i_sclk;
    nxt_st.clr = 1'b0; // R18
    nxt_st.fault = fault_any; // R2
    case (st_ff.fsm)
      GDR_IDLE: begin
        nxt_st.sdo_rel = 1'b1;
        if (!i_cs_n) begin
          nxt_st.fsm = GDR_SHIFT;
          nxt_st.cnt = '0;
        end
      end
      GDR_SHIFT: begin
        if (i_cs_n) begin
          nxt_st.sdo_rel = 1'b1;
          // short or long frames are dropped
          nxt_st.fsm = (st_ff.cnt == CNT_FULL) ? GDR_COMMIT : GDR_IDLE; // R19
        end else begin
          if (sclk_fall) begin
            if (st_ff.cnt != CNT_OVER) begin
              nxt_st.cnt = st_ff.cnt + 5'h01;
            end
            if (st_ff.cnt < CNT_FULL) begin
              nxt_st.rx = {st_ff.rx[14:0], i_sdi}; // R19
            end
            // address known after the fifth bit: fetch the reply word
            if (st_ff.cnt == CNT_CMD - 5'h01) begin
              nxt_st.tx = read_word({st_ff.rx[2:0], i_sdi}, st_ff, word1_flags,
                                    word2_flags); // R22
            end
          end
          if (sclk_rise) begin
            if (st_ff.cnt >= CNT_CMD && st_ff.cnt < CNT_FULL) begin
              nxt_st.sdo_rel = st_ff.tx[DATA_W-1];
              nxt_st.tx = {st_ff.tx[9:0], 1'b0};
            end else begin
              nxt_st.sdo_rel = 1'b1;
            end
          end
        end
      end
      GDR_COMMIT: begin
        nxt_st.fsm = GDR_IDLE;
        if (!st_ff.rx[RW_POS]) begin
          case (wr_addr)
            ADDR_DRIVER_CONTROL: begin
              if (st_ff.lock == LOCK_ENGAGE) begin
                nxt_st.ctrl[CTL_HIZ:CTL_LOW_SIDE_ALL_ON] = wr_data[CTL_HIZ:CTL_LOW_SIDE_ALL_ON]; // R20
              end else begin
                nxt_st.ctrl = {wr_data[10:1], 1'b0}; // R8
              end
              nxt_st.clr = wr_data[CTL_CLR]; // R18 R20
            end
            ADDR_WRITE_LOCK: begin
              if (st_ff.lock == LOCK_ENGAGE) begin
                if (wr_data[LOCK_MSB:LOCK_LSB] == LOCK_RELEASE) begin
                  nxt_st.lock = LOCK_RELEASE; // R20
                end
              end else if (wr_data[LOCK_MSB:LOCK_LSB] == LOCK_ENGAGE) begin
                nxt_st.lock = LOCK_ENGAGE; // R20
              end
            end
            // status words and unmapped addresses take no writes
            default: nxt_st.ctrl = st_ff.ctrl; // R1
          endcase
        end
      end
      default: nxt_st.fsm = GDR_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_ff.fsm <= GDR_IDLE;
      st_ff.sclk_prev <= 1'b0;
      st_ff.rx <= '0;
      st_ff.cnt <= '0;
      st_ff.tx <= '0;
      st_ff.sdo_rel <= 1'b1;
      st_ff.ctrl <= CTL_RST; // R8
      st_ff.lock <= LOCK_RST;
      st_ff.clr <= 1'b0;
      st_ff.fault <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only ever pulls low, released while deselected
  assign o_sdo = 1'b0;
  assign o_sdo_oe = ~i_cs_n & (st_ff.fsm == GDR_SHIFT) & ~st_ff.sdo_rel;
  assign o_error_indicator_n = ~st_ff.fault; // R2

  gdr_bridge_ctrl u_bridge (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ctrl(st_ff.ctrl),
    .i_ds_flags(word1_flags[5:0]),
    .i_shunt_flags({word2_flags[10], word2_flags[9], word2_flags[8]}),
    .i_phase_c_high_input(i_phase_c_high_input),
    .i_phase_c_low_input(i_phase_c_low_input),
    .o_halfbridge_off(o_halfbridge_off),
    .o_all_transistors_hiz(o_all_transistors_hiz),
    .o_low_side_all_on(o_low_side_all_on),
    .o_single_input_direction(o_single_input_direction),
    .o_single_input_rectify_async(o_single_input_rectify_async),
    .o_pwm_mode(o_pwm_mode)
  );

endmodule // gdr_regs

// ===== tb/gdr_regs_monitor.sv
// concurrent checks on the ports of the gate driver register bank
`timescale 1ns/1ns
module gdr_regs_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic [5:0] i_ds_overcurrent,
  input wire logic i_phase_c_high_input,
  input wire logic i_phase_c_low_input,
  input wire logic o_error_indicator_n,
  input wire logic [2:0] o_halfbridge_off,
  input wire logic o_low_side_all_on,
  input wire logic o_single_input_direction,
  input wire logic o_single_input_rectify_async,
  input wire logic [1:0] o_pwm_mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ----
  // assertions
  // ----
  a_reply_released: assert property (i_cs_n |-> !o_sdo_oe)
    else $error("reply line pulled while deselected");
  a_reply_level: assert property (o_sdo_oe |-> o_sdo == 1'b0)
    else $error("reply line driven high");
  a_pin_after_reset: assert property ($fell(i_rst) |-> o_error_indicator_n)
    else $error("error pin low straight after reset");
  a_pin_on_fault: assert property (|i_ds_overcurrent |-> ##[1:4] !o_error_indicator_n)
    else $error("error pin missed an overcurrent");
  // a clear only commits after deselect, so mid-frame the pin must hold
  a_pin_sticky: assert property ((!i_cs_n)[*8] ##0 !o_error_indicator_n |=> !o_error_indicator_n)
    else $error("latched fault vanished without a clear");
  a_bridge_shutdown: assert property ($rose(i_ds_overcurrent[5]) |-> ##[1:4] o_halfbridge_off[2])
    else $error("phase a not shut down on overcurrent");
  // pin seen one edge before the mode copy that was registered alongside the output
  a_dir_from_pin: assert property (i_phase_c_high_input ##1 (o_pwm_mode == 2'h2)
    |-> o_single_input_direction)
    else $error("direction pin ignored in single-input mode");
  a_low_side_all_on_from_pin: assert property (i_phase_c_low_input ##1 (o_pwm_mode == 2'h2)
    |-> o_low_side_all_on)
    else $error("low_side_all_on pin ignored in single-input mode");
  a_steer_hold: assert property ((!i_cs_n)[*8]
    |=> $stable({o_pwm_mode, o_single_input_rectify_async}))
    else $error("control outputs moved during a frame");
  c_reply_bit: cover property (!i_cs_n && o_sdo_oe);
  c_fault_seen: cover property ($fell(o_error_indicator_n));
  c_all_off: cover property (o_halfbridge_off == 3'h7);
endmodule // gdr_regs_monitor

// ===== tb/gdr_spi_master.sv
// serial master model standing in for the motor controller
`timescale 1ns/1ns
module gdr_spi_master (
  input wire logic i_sys_clk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  logic line;
  // open-drain reply with its pull-up
  assign line = i_sdo_oe ? i_sdo : 1'b1;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // ----
  // one frame, msb first; nb below 16 makes a broken frame
  // ----
  task automatic xfer(input logic [15:0] w, input int nb, output logic [10:0] r);
    r = '0;
    @(posedge i_sys_clk);
    o_cs_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    for (int i = 15; i > 15 - nb; i--) begin
      o_sdi <= w[i];
      repeat (2) @(posedge i_sys_clk);
      o_sclk <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      if (i <= 10) begin
        r[i] = line;
      end
      @(posedge i_sys_clk);
      o_sclk <= 1'b0;
      // the fall is seen one edge late, so the bit must still stand then
      @(posedge i_sys_clk);
    end
    repeat (3) @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    // released data line must not keep showing the last bit
    o_sdi <= ~o_sdi;
    repeat (6) @(posedge i_sys_clk);
  endtask
endmodule // gdr_spi_master

// ===== tb/testbench.sv
// self-checking bench for the gate driver register bank
`timescale 1ns/1ns
module testbench;
  import gdr_pkg::*;
  logic clk;
  logic rst;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic [18:0] ev;
  logic phc_hi;
  logic phc_lo;
  logic err_n;
  logic [2:0] hb_off;
  logic hiz;
  logic low_side_all_on;
  logic dir;
  logic rect;
  logic [1:0] mode;
  int err_count;
  int samples_checked;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  gdr_regs u_gdr_regs (.i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_ds_overcurrent(ev[18:13]),
    .i_gs_error(ev[12:7]), .i_shunt_overcurrent(ev[6:4]), .i_supply_undervoltage(ev[3]),
    .i_overtemp_shutdown(ev[2]), .i_overtemp_warning(ev[1]),
    .i_gate_supply_undervoltage(ev[0]), .i_phase_c_high_input(phc_hi),
    .i_phase_c_low_input(phc_lo), .o_error_indicator_n(err_n), .o_halfbridge_off(hb_off),
    .o_all_transistors_hiz(hiz), .o_low_side_all_on(low_side_all_on), .o_single_input_direction(dir),
    .o_single_input_rectify_async(rect), .o_pwm_mode(mode));
  gdr_spi_master u_gdr_spi_master (.i_sys_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
  // ----
  // helpers
  // ----
  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [10:0] d, input int nb = 16);
    logic [10:0] r;
    u_gdr_spi_master.xfer({1'b0, a, d}, nb, r);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [10:0] e);
    logic [10:0] r;
    u_gdr_spi_master.xfer({1'b1, a, 11'h000}, 16, r);
    chk($sformatf("reg %0h", a), e, r);
  endtask
  // one-cycle detector events, then time for latch and summary
  task automatic pulse(input logic [18:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    repeat (4) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  // ----
  // main sequence
  // ----
  initial begin
    rst = 1'b1;
    ev = '0;
    phc_hi = 1'b0;
    phc_lo = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(4'h0, ST_RST);
    rd_chk(4'h1, ST_RST);
    rd_chk(4'h2, CTL_RST);
    rd_chk(4'h3, 11'h300);
    rd_chk(4'h5, 11'h000);
    chk("error pin", 11'h001, err_n);
    for (int m = 0; m < 4; m++) begin
      wr(4'h2, {4'hf, 2'(m), 5'h1f});
      rd_chk(4'h2, {4'hf, 2'(m), 5'h1e});
      chk("pwm mode", 11'(m), mode);
      chk("hiz", 11'h001, hiz);
      chk("low side on", 11'h001, low_side_all_on);
      if (m == 2) begin
        chk("rectify", 11'h001, rect);
        chk("direction", 11'h001, dir);
      end
    end
    wr(4'h2, 11'h040);
    phc_hi <= 1'b1;
    phc_lo <= 1'b1;
    repeat (4) @(posedge clk);
    chk("direction pin", 11'h001, dir);
    chk("low_side_all_on pin", 11'h001, low_side_all_on);
    wr(4'h2, 11'h000);
    chk("direction six", 11'h000, dir);
    chk("low_side_all_on six", 11'h000, low_side_all_on);
    phc_hi <= 1'b0;
    phc_lo <= 1'b0;
    pulse(19'h40000);
    rd_chk(4'h0, 11'h620);
    chk("error pin low", 11'h000, err_n);
    chk("one bridge off", 11'h004, hb_off);
    wr(4'h0, 11'h000);
    wr(4'h2, 11'h400);
    chk("all bridges off", 11'h007, hb_off);
    rd_chk(4'h0, 11'h620);
    wr(4'h2, 11'h001);
    rd_chk(4'h0, 11'h000);
    rd_chk(4'h2, 11'h000);
    chk("error pin clear", 11'h001, err_n);
    pulse(19'h01fff);
    rd_chk(4'h0, 11'h5c0);
    rd_chk(4'h1, 11'h7ff);
    chk("shunt bridges off", 11'h007, hb_off);
    wr(4'h1, 11'h000);
    rd_chk(4'h1, 11'h7ff);
    wr(4'h2, 11'h001);
    pulse(19'h00002);
    rd_chk(4'h1, 11'h080);
    rd_chk(4'h0, 11'h000);
    chk("warning hidden", 11'h001, err_n);
    wr(4'h2, 11'h080);
    rd_chk(4'h0, 11'h400);
    chk("warning shown", 11'h000, err_n);
    wr(4'h2, 11'h081);
    rd_chk(4'h1, 11'h000);
    rd_chk(4'h2, 11'h080);
    wr(4'h2, 11'h300);
    pulse(19'h01f81);
    rd_chk(4'h0, 11'h000);
    rd_chk(4'h1, 11'h000);
    wr(4'h3, 11'h600);
    wr(4'h2, 11'h7fe);
    rd_chk(4'h2, 11'h306);
    wr(4'h3, 11'h300);
    rd_chk(4'h3, 11'h300);
    wr(4'h2, 11'h000);
    wr(4'h2, 11'h0c0, 15);
    rd_chk(4'h2, 11'h000);
    report_and_stop();
  end
endmodule // testbench
bind gdr_regs gdr_regs_monitor u_gdr_regs_monitor (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .i_ds_overcurrent(i_ds_overcurrent),
  .i_phase_c_high_input(i_phase_c_high_input), .i_phase_c_low_input(i_phase_c_low_input),
  .o_error_indicator_n(o_error_indicator_n), .o_halfbridge_off(o_halfbridge_off),
  .o_low_side_all_on(o_low_side_all_on), .o_single_input_direction(o_single_input_direction),
  .o_single_input_rectify_async(o_single_input_rectify_async), .o_pwm_mode(o_pwm_mode));
